// *** hssc_switch_ctrl.sv ***
`timescale 1ns/100ps
`include "hssc_params.svh"
module hssc_switch_ctrl import hssc_pkg::*; #(
  parameter int CNT_W       = 25,
  parameter int T2_ON1_CYC  = `HSSC_T_ON1_US * `HSSC_CLK_MHZ,
  parameter int T2_ON2_CYC  = `HSSC_T_ON2_US * `HSSC_CLK_MHZ,
  parameter int T2_ON3_CYC  = `HSSC_T_ON3_US * `HSSC_CLK_MHZ,
  parameter int T2_ON4_CYC  = `HSSC_T_ON4_US * `HSSC_CLK_MHZ,
  parameter int T2_ON5_CYC  = `HSSC_T_ON5_US * `HSSC_CLK_MHZ,
  parameter int T2_PER0_CYC = `HSSC_T_PER0_US * `HSSC_CLK_MHZ,
  parameter int T2_PER1_CYC = `HSSC_T_PER1_US * `HSSC_CLK_MHZ,
  parameter int T2_PER2_CYC = `HSSC_T_PER2_US * `HSSC_CLK_MHZ,
  parameter int T2_PER3_CYC = `HSSC_T_PER3_US * `HSSC_CLK_MHZ,
  parameter int T2_PER4_CYC = `HSSC_T_PER4_US * `HSSC_CLK_MHZ,
  parameter int T2_PER5_CYC = `HSSC_T_PER5_US * `HSSC_CLK_MHZ,
  parameter int T2_PER6_CYC = `HSSC_T_PER6_US * `HSSC_CLK_MHZ
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       soft_rst,
  input  wire logic       restart_mode,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       first_timer_lvl,
  input  wire logic       first_duty_lvl,
  input  wire logic       second_duty_lvl,
  input  wire logic       supply_ov,
  input  wire logic       supply_uv,
  input  wire logic [3:0] sw_overcurrent,
  input  wire logic [3:0] sw_overtemp,
  output logic      [7:0] reg_rdata_ff,
  output logic      [3:0] sw_drive_ff,
  output logic            second_timer_sample_ff,
  output logic            supply_shutdown_ff
);
  logic [7:0]       tmr_ff;       // Second timer control register.
  logic [7:0]       sd_ff;        // Supply shutdown control register.
  logic [7:0]       sela_ff;      // Switches one and two source select.
  logic [7:0]       selb_ff;      // Switches three and four source select.
  logic [7:0]       nxt_tmr;      // Next timer register value.
  logic [7:0]       nxt_sd;       // Next shutdown register value.
  logic [7:0]       nxt_sela;     // Next select A value.
  logic [7:0]       nxt_selb;     // Next select B value.
  logic [9:0]       meta_ff;      // First synchroniser stage of the pins.
  logic [9:0]       sync_ff;      // Second synchroniser stage.
  logic             restart_d_ff; // Restart mode level one cycle ago.
  logic             sd_hold_ff;   // Shutdown latched without recovery.
  logic             nxt_sd_hold;  // Next latch value.
  logic             t2_lvl;       // Second timer output level.
  logic             t2_sample;    // Second timer end-of-on-time strobe.
  logic [3:0]       sw_lvl;       // Raw per-switch source level.
  logic [3:0]       nxt_drive;    // Gated per-switch drive.
  logic [11:0]      sw_code;      // All four switch fields side by side.

  // Pins arrive from the analog side, so each passes two flops first.
  wire              ov_s    = sync_ff[9];
  wire              uv_s    = sync_ff[8];
  wire [3:0]        fault_s = sync_ff[7:4] | sync_ff[3:0];

  // Address decoding.
  wire              hit_tmr  = (reg_addr == `HSSC_ADDR_TMR);
  wire              hit_sd   = (reg_addr == `HSSC_ADDR_SD);
  wire              hit_sela = (reg_addr == `HSSC_ADDR_SELA);
  wire              hit_selb = (reg_addr == `HSSC_ADDR_SELB);
  wire              wr_tmr   = reg_wr && hit_tmr;
  wire              wr_sd    = reg_wr && hit_sd;
  wire              wr_sela  = reg_wr && hit_sela;
  wire              wr_selb  = reg_wr && hit_selb;
  wire              restart_entry = restart_mode && !restart_d_ff;

  // Read selection; unmapped addresses answer zero.
  wire [7:0]        rd_val = hit_tmr  ? tmr_ff  :
                             hit_sd   ? sd_ff   :
                             hit_sela ? sela_ff :
                             hit_selb ? selb_ff : `HSSC_RST_VAL;

  // Field views.
  wire [2:0]        on_code  = tmr_ff[`HSSC_ON_LSB +: 3];
  wire [2:0]        per_code = tmr_ff[`HSSC_PER_LSB +: 3];

  // Supply fault shutdown unless its disable bit is set.
  wire              ov_trip = ov_s && !sd_ff[`HSSC_SD_OV_BIT];
  wire              uv_trip = uv_s && !sd_ff[`HSSC_SD_UV_BIT];
  wire              sd_now  = ov_trip || uv_trip;
  wire              sd_rec  = sd_ff[`HSSC_SD_REC_BIT];

  // Candidate select values after a write, masked to the live bits.
  wire [7:0]        sela_w = wr_sela ? (reg_wdata & `HSSC_MASK_SEL) : sela_ff;
  wire [7:0]        selb_w = wr_selb ? (reg_wdata & `HSSC_MASK_SEL) : selb_ff;

  // Second timer counts chosen from the codes.
  wire [CNT_W-1:0]  t2_on_cyc =
      (on_code == 3'h1) ? CNT_W'(T2_ON1_CYC) :
      (on_code == 3'h2) ? CNT_W'(T2_ON2_CYC) :
      (on_code == 3'h3) ? CNT_W'(T2_ON3_CYC) :
      (on_code == 3'h4) ? CNT_W'(T2_ON4_CYC) :
      (on_code == 3'h5) ? CNT_W'(T2_ON5_CYC) : '0;
  wire [CNT_W-1:0]  t2_per_cyc =
      (per_code == 3'h0) ? CNT_W'(T2_PER0_CYC) :
      (per_code == 3'h1) ? CNT_W'(T2_PER1_CYC) :
      (per_code == 3'h2) ? CNT_W'(T2_PER2_CYC) :
      (per_code == 3'h3) ? CNT_W'(T2_PER3_CYC) :
      (per_code == 3'h4) ? CNT_W'(T2_PER4_CYC) :
      (per_code == 3'h5) ? CNT_W'(T2_PER5_CYC) :
      (per_code == 3'h6) ? CNT_W'(T2_PER6_CYC) : '0;

  // Is any switch driven from the second timer.
  function automatic logic uses_t2(input logic [7:0] a, input logic [7:0] b);
    uses_t2 = (a[2:0] == SRC_TMR2) || (a[6:4] == SRC_TMR2) ||
              (b[2:0] == SRC_TMR2) || (b[6:4] == SRC_TMR2);
  endfunction : uses_t2

  // Source multiplexer of one switch; reserved codes stay off.
  // Every level comes in as an argument, so the continuous assignment re-evaluates on each.
  function automatic logic src_lvl(input logic [2:0] code, input logic t2, input logic t1,
                                   input logic p1, input logic p2);
    case (code)
      SRC_ON:   src_lvl = 1'b1;
      SRC_TMR1: src_lvl = t1;
      SRC_TMR2: src_lvl = t2;
      SRC_FIRST_DUTY_GENERATOR: src_lvl = p1;
      SRC_SECOND_DUTY_GENERATOR: src_lvl = p2;
      default:  src_lvl = 1'b0;
    endcase
  endfunction : src_lvl

  // Clearing cyclic-sense switches in restart mode drops the timer too.
  wire              t2_sense_clr = restart_mode && (wr_sela || wr_selb) &&
                                   uses_t2(sela_ff, selb_ff) && !uses_t2(sela_w, selb_w);

  assign sw_code = {selb_ff[6:4], selb_ff[2:0], sela_ff[6:4], sela_ff[2:0]};

  // One mux per switch.
  for (genvar i = 0; i < 4; i++) begin : g_sw
    assign sw_lvl[i] = src_lvl(sw_code[3*i +: 3], t2_lvl, first_timer_lvl,
                               first_duty_lvl, second_duty_lvl);
  end

  // A tripped supply forces every switch off; without recovery it stays off until a select register is written.
  assign nxt_drive = (sd_now || sd_hold_ff) ? 4'h0 : sw_lvl;

  // Register next values; hardware fault clears win over a host write.
  always_comb begin
    nxt_tmr  = tmr_ff;
    nxt_sd   = sd_ff;
    nxt_sela = sela_w;
    nxt_selb = selb_w;
    if (soft_rst) begin
      nxt_tmr  = `HSSC_RST_VAL;
      nxt_sd   = `HSSC_RST_VAL;
      nxt_sela = `HSSC_RST_VAL;
      nxt_selb = `HSSC_RST_VAL;
    end else if (restart_entry) begin
      nxt_tmr  = `HSSC_RST_VAL;
      nxt_sd   = sd_ff & `HSSC_RESTART_KEEP;
      nxt_sela = `HSSC_RST_VAL;
      nxt_selb = `HSSC_RST_VAL;
    end else begin
      if (t2_sense_clr) begin
        nxt_tmr = `HSSC_RST_VAL;
      end else if (wr_tmr) begin
        nxt_tmr = reg_wdata & `HSSC_MASK_TMR;
      end
      if (wr_sd) begin
        nxt_sd = reg_wdata & `HSSC_MASK_SD;
      end
      if (fault_s[0]) nxt_sela[2:0] = 3'h0;
      if (fault_s[1]) nxt_sela[6:4] = 3'h0;
      if (fault_s[2]) nxt_selb[2:0] = 3'h0;
      if (fault_s[3]) nxt_selb[6:4] = 3'h0;
    end
  end

  // Latched shutdown: a new trip wins over the host's rewrite.
  always_comb begin
    nxt_sd_hold = sd_hold_ff;
    if (soft_rst) begin
      nxt_sd_hold = 1'b0;
    end else if (sd_now && !sd_rec) begin
      nxt_sd_hold = 1'b1;
    end else if (sd_rec || wr_sela || wr_selb) begin
      nxt_sd_hold = 1'b0;
    end
  end

  // Two-stage synchroniser for the analog fault pins.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= {supply_ov, supply_uv, sw_overtemp, sw_overcurrent};
      sync_ff <= meta_ff;
    end
  end

  // Register bank; power-on reset clears everything.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tmr_ff       <= `HSSC_RST_VAL;
      sd_ff        <= `HSSC_RST_VAL;
      sela_ff      <= `HSSC_RST_VAL;
      selb_ff      <= `HSSC_RST_VAL;
      restart_d_ff <= 1'b0;
      sd_hold_ff   <= 1'b0;
    end else if (ce) begin
      tmr_ff       <= nxt_tmr;
      sd_ff        <= nxt_sd;
      sela_ff      <= nxt_sela;
      selb_ff      <= nxt_selb;
      restart_d_ff <= restart_mode;
      sd_hold_ff   <= nxt_sd_hold;
    end
  end

  // Output flops; read data holds until the next read.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata_ff           <= `HSSC_RST_VAL;
      sw_drive_ff            <= 4'h0;
      second_timer_sample_ff <= 1'b0;
      supply_shutdown_ff     <= 1'b0;
    end else if (ce) begin
      if (reg_rd) reg_rdata_ff <= rd_val;
      sw_drive_ff            <= nxt_drive;
      second_timer_sample_ff <= t2_sample;
      supply_shutdown_ff     <= sd_now || sd_hold_ff;
    end
  end

  // The second timer; a write to its register restarts the period.
  hssc_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .ce        (ce),
    .start     (wr_tmr),
    .on_code   (on_code),
    .per_code  (per_code),
    .on_cyc    (t2_on_cyc),
    .per_cyc   (t2_per_cyc),
    .lvl_ff    (t2_lvl),
    .sample_ff (t2_sample)
  );

  property p_on_zero_low;
    @(posedge ref_clk) disable iff (!nrst) (ce && on_code == `HSSC_ON_OFF_LOW) |=> !t2_lvl;
  endproperty
  a_on_zero_low: assert property (p_on_zero_low) else $error("timer not low");

  property p_on_high;
    @(posedge ref_clk) disable iff (!nrst) (ce && on_code == `HSSC_ON_OFF_HIGH) |=> t2_lvl;
  endproperty
  a_on_high: assert property (p_on_high) else $error("timer not high");

  sequence s_start_write;
    ce && wr_tmr && !soft_rst && !restart_mode && reg_wdata[6:4] inside {[3'h1:3'h5]} &&
    reg_wdata[2:0] != `HSSC_CODE_RSV ##1 ce;
  endsequence
  property p_autostart;
    @(posedge ref_clk) disable iff (!nrst) s_start_write |=> t2_lvl;
  endproperty
  a_autostart: assert property (p_autostart) else $error("timer did not start");

  property p_sense_clear;
    @(posedge ref_clk) disable iff (!nrst) (ce && t2_sense_clr) |=> tmr_ff == 8'h00;
  endproperty
  a_sense_clear: assert property (p_sense_clear) else $error("timer not cleared");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (!nrst)
      reg_rdata_ff[7] == 1'b0 && reg_rdata_ff[3] == 1'b0 && sd_ff[3:0] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_ov_off;
    @(posedge ref_clk) disable iff (!nrst) (ce && ov_s && !sd_ff[6]) |=> sw_drive_ff == 4'h0;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("overvoltage left a switch on");

  property p_uv_off;
    @(posedge ref_clk) disable iff (!nrst) (ce && uv_s && !sd_ff[5]) |=> sw_drive_ff == 4'h0;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("undervoltage left a switch on");

  sequence s_fault_ends;
    ce && $fell(sd_now) && sd_rec && !sd_hold_ff && sela_ff[2:0] == 3'h1;
  endsequence
  property p_recover;
    @(posedge ref_clk) disable iff (!nrst) s_fault_ends |=> sw_drive_ff[0];
  endproperty
  a_recover: assert property (p_recover) else $error("switch not restored");

  property p_sw4_on;
    @(posedge ref_clk) disable iff (!nrst)
      (ce && selb_ff[6:4] == 3'h1 && !sd_now && !sd_hold_ff) |=> sw_drive_ff[3];
  endproperty
  a_sw4_on: assert property (p_sw4_on) else $error("switch four not on");

  property p_fault_clear;
    @(posedge ref_clk) disable iff (!nrst) (ce && fault_s[0] && !soft_rst) |=> sela_ff[2:0] == 3'h0;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("faulted field kept");

  property p_restart_keep;
    @(posedge ref_clk) disable iff (!nrst)
      (ce && restart_entry && !soft_rst) |=> sd_ff == ($past(sd_ff) & 8'h70) && sela_ff == 8'h00;
  endproperty
  a_restart_keep: assert property (p_restart_keep) else $error("restart values wrong");

  property p_reserved_off;
    @(posedge ref_clk) disable iff (!nrst) (ce && sela_ff[2:0] >= 3'h6) |=> !sw_drive_ff[0];
  endproperty
  a_reserved_off: assert property (p_reserved_off) else $error("reserved code drove switch");
endmodule : hssc_switch_ctrl

// *** hssc_params.svh ***
`ifndef HSSC_PARAMS_SVH
`define HSSC_PARAMS_SVH
// Contract
// - On-time 000 stops timer, outputs low.
// - On-time codes 001-101 pick 0.1-20 ms.
// - On-time 110 stops timer, outputs high.
// - Period codes 000-110 pick 10 ms-2 s.
// - Writing running on-time starts timer automatically.
// - Restart-mode switch clear also clears timer.
// - Reserved bits ignore writes, read zero.
// - Bit 6 clear: overvoltage switches all off.
// - Bit 5 clear: undervoltage switches all off.
// - Bit 4 set restores switches after fault.
// - Switch field codes select output source.
// - Switch fields sit at bits 2:0, 6:4.
// - Overcurrent or overtemperature clears switch field.
// - Resets clear all; restart keeps shutdown 6:4.
// - Wake sample strobe at end of on-time.

// Register addresses on the 7-bit command address.
`define HSSC_ADDR_TMR      7'h0d
`define HSSC_ADDR_SD       7'h10
`define HSSC_ADDR_SELA     7'h14
`define HSSC_ADDR_SELB     7'h15

// Writable masks; everything outside reads as zero.
`define HSSC_MASK_TMR      8'h77
`define HSSC_MASK_SD       8'h70
`define HSSC_MASK_SEL      8'h77
`define HSSC_RST_VAL       8'h00
`define HSSC_RESTART_KEEP  8'h70

// Field positions.
`define HSSC_ON_LSB        4
`define HSSC_PER_LSB       0
`define HSSC_SD_OV_BIT     6
`define HSSC_SD_UV_BIT     5
`define HSSC_SD_REC_BIT    4

// Timer codes with special meaning.
`define HSSC_ON_OFF_LOW    3'h0
`define HSSC_ON_OFF_HIGH   3'h6
`define HSSC_CODE_RSV      3'h7

// Clock rate and timer figures in microseconds.
`define HSSC_CLK_MHZ       10
`define HSSC_T_ON1_US      100
`define HSSC_T_ON2_US      300
`define HSSC_T_ON3_US      1000
`define HSSC_T_ON4_US      10000
`define HSSC_T_ON5_US      20000
`define HSSC_T_PER0_US     10000
`define HSSC_T_PER1_US     20000
`define HSSC_T_PER2_US     50000
`define HSSC_T_PER3_US     100000
`define HSSC_T_PER4_US     200000
`define HSSC_T_PER5_US     1000000
`define HSSC_T_PER6_US     2000000
`endif

// *** hssc_pkg.sv ***
package hssc_pkg;
  // Output source selection codes of one switch field.
  typedef enum logic [2:0] {
    SRC_OFF  = 3'h0,
    SRC_ON   = 3'h1,
    SRC_TMR1 = 3'h2,
    SRC_TMR2 = 3'h3,
    SRC_FIRST_DUTY_GENERATOR = 3'h4,
    SRC_SECOND_DUTY_GENERATOR = 3'h5
  } hssc_src_t;

  // Cyclic timer states.
  typedef enum logic {TMR_IDLE, TMR_RUN} hssc_tmr_st_t;
endpackage : hssc_pkg

// *** hssc_timer.sv ***
`timescale 1ns/100ps
`include "hssc_params.svh"
module hssc_timer import hssc_pkg::*; #(
  parameter int CNT_W = 25
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             start,
  input  wire logic [2:0]       on_code,
  input  wire logic [2:0]       per_code,
  input  wire logic [CNT_W-1:0] on_cyc,
  input  wire logic [CNT_W-1:0] per_cyc,
  output logic                  lvl_ff,
  output logic                  sample_ff
);
  hssc_tmr_st_t     st_ff;      // Idle or counting.
  hssc_tmr_st_t     nxt_st;     // Next state.
  logic [CNT_W-1:0] cnt_ff;     // Position inside the period.
  logic [CNT_W-1:0] nxt_cnt;    // Next position.
  logic             nxt_lvl;    // Next output level.
  logic             nxt_sample; // Next sample strobe.
  wire              run_ok;     // A running on-time and a legal period.

  // Reserved codes never run the timer.
  assign run_ok = (on_code != `HSSC_ON_OFF_LOW) && (on_code != `HSSC_ON_OFF_HIGH) &&
                  (on_code != `HSSC_CODE_RSV) && (per_code != `HSSC_CODE_RSV);

  // Next-state logic; a write restarts the period at its start.
  always_comb begin
    nxt_st     = st_ff;
    nxt_cnt    = cnt_ff;
    nxt_sample = 1'b0;
    case (st_ff)
      TMR_IDLE: begin
        nxt_cnt = '0;
        if (run_ok) begin
          nxt_st  = TMR_RUN;
          nxt_cnt = CNT_W'(1);
        end
      end
      TMR_RUN: begin
        if (!run_ok) begin
          nxt_st  = TMR_IDLE;
          nxt_cnt = '0;
        end else if (start) begin
          nxt_cnt = '0;
        end else if (cnt_ff >= per_cyc - CNT_W'(1)) begin
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
        nxt_sample = run_ok && (cnt_ff == on_cyc - CNT_W'(1));
      end
      default: nxt_st = TMR_IDLE;
    endcase
    // Static codes hold the output without counting.
    if (!run_ok) begin
      nxt_lvl = (on_code == `HSSC_ON_OFF_HIGH);
    end else if (st_ff == TMR_IDLE) begin
      nxt_lvl = 1'b1;
    end else begin
      nxt_lvl = (cnt_ff < on_cyc);
    end
  end

  // State registers.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_ff     <= TMR_IDLE;
      cnt_ff    <= '0;
      lvl_ff    <= 1'b0;
      sample_ff <= 1'b0;
    end else if (ce) begin
      st_ff     <= nxt_st;
      cnt_ff    <= nxt_cnt;
      lvl_ff    <= nxt_lvl;
      sample_ff <= nxt_sample;
    end
  end

  // The strobe is one cycle long whenever the period exceeds the on-time by more than one cycle.
  property p_sample_single;
    @(posedge ref_clk) disable iff (!nrst)
      (ce && sample_ff && per_cyc > on_cyc + CNT_W'(1)) |=> !sample_ff;
  endproperty
  a_sample_single: assert property (p_sample_single) else $error("sample strobe too long");
endmodule : hssc_timer

// *** hssc_host.sv ***
`timescale 1ns/100ps
// Host side of the register port: one strobe per command.
module hssc_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] rdata,
  output logic            wr,
  output logic            rd,
  output logic      [6:0] addr,
  output logic      [7:0] wdata
);
  // Address and data lines start at all ones, strobes at zero; the address 7'h7f never appears in a command.
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 7'h7f;
    wdata = 8'hff;
  end

  // One command for one edge; released lines show the inverse so stale data is never reused.
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : xfer

  // Read data lands one cycle after the strobe edge.
  task automatic read(input logic [6:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    #1 d = rdata;
  endtask : read
endmodule : hssc_host

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top import hssc_pkg::*;;
  logic       ref_clk, nrst, ce, soft_rst, restart_mode, ft, fd, sd2, ov, uv;
  logic [3:0] oc, ot, drv;
  logic       reg_wr, reg_rd, smp, shut;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, rdata;
  int         num_errors, checked, hi, ns;
  // Shortened timer figures in clock cycles, so a whole period fits a short run.
  localparam int ON1 = 2, ON2 = 3, ON3 = 4, ON4 = 6, ON5 = 10;
  localparam int PER0 = 20, PER1 = 30, PER2 = 40, PER3 = 50, PER4 = 60, PER5 = 70, PER6 = 80;
  // The same figures indexed by code, for the expected values.
  int         on_cyc[6] = '{0, ON1, ON2, ON3, ON4, ON5};
  int         per_cyc[7] = '{PER0, PER1, PER2, PER3, PER4, PER5, PER6};
  logic [6:0] adr[4] = '{7'h0d, 7'h10, 7'h14, 7'h15};
  logic [7:0] msk[4] = '{8'h77, 8'h70, 8'h77, 8'h77};
  logic [7:0] spc[4] = '{8'h60, 8'h00, 8'h70, 8'h17};
  int         spx[4] = '{20, 0, 0, 0};

  hssc_switch_ctrl #(.T2_ON1_CYC(ON1), .T2_ON2_CYC(ON2), .T2_ON3_CYC(ON3), .T2_ON4_CYC(ON4),
    .T2_ON5_CYC(ON5), .T2_PER0_CYC(PER0), .T2_PER1_CYC(PER1), .T2_PER2_CYC(PER2),
    .T2_PER3_CYC(PER3), .T2_PER4_CYC(PER4), .T2_PER5_CYC(PER5),
    .T2_PER6_CYC(PER6)) i_hssc_switch_ctrl (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .soft_rst(soft_rst),
    .restart_mode(restart_mode), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .first_timer_lvl(ft), .first_duty_lvl(fd), .second_duty_lvl(sd2),
    .supply_ov(ov), .supply_uv(uv), .sw_overcurrent(oc), .sw_overtemp(ot),
    .reg_rdata_ff(rdata), .sw_drive_ff(drv), .second_timer_sample_ff(smp),
    .supply_shutdown_ff(shut));

  hssc_host i_hssc_host (.ref_clk(ref_clk), .rdata(rdata), .wr(reg_wr), .rd(reg_rd),
    .addr(reg_addr), .wdata(reg_wdata));

  // Free-running 100 ns clock.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(logic [6:0] a, logic [7:0] d);
    i_hssc_host.xfer(1'b1, a, d);
  endtask : wr

  task automatic rdchk(string what, logic [6:0] a, logic [7:0] exp);
    logic [7:0] d;
    i_hssc_host.read(a, d);
    chk(what, exp, d);
  endtask : rdchk

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // Counts drive-high and sample cycles of switch one from the third cycle after a write.
  task automatic measure(int n);
    hi = 0;
    ns = 0;
    @(posedge ref_clk);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      hi += (drv[0] === 1'b1);
      ns += (smp === 1'b1);
    end
  endtask : measure

  // A hang is cut short here and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    $display("Error timeout expected done seen hang");
    tally_and_finish();
  end

  initial begin
    {nrst, soft_rst, restart_mode, ft, fd, sd2, ov, uv, oc, ot} = '0;
    ce = 1'b1;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) rdchk("reset value", adr[i], 8'h00);
    rdchk("unmapped", 7'h11, 8'h00);
    // Reserved bits drop; the reserved codes left behind must keep switches off.
    for (int i = 0; i < 4; i++) begin
      wr(adr[i], 8'hff);
      rdchk("masked", adr[i], msk[i]);
    end
    cyc(4);
    chk("reserved drive", 8'h00, {4'h0, drv});
    for (int i = 0; i < 4; i++) wr(adr[i], 8'h00);
    $display("Register access test done");
    // Every source code with its own external level high, then with all levels low.
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 8; c++) begin
        // Only the named source is raised, so a swapped mux input shows up.
        @(posedge ref_clk) {ft, fd, sd2} <= {p == 0 && c == 2, p == 0 && c == 4, p == 0 && c == 5};
        wr(7'h14, {1'b0, c[2:0], 1'b0, c[2:0]});
        cyc(4);
        chk("source", (p == 0 && c inside {1, 2, 4, 5}) || c == 1 ? 8'h03 : 8'h00,
          {6'h0, drv[1:0]});
      end
    end
    for (int i = 0; i < 4; i++) begin
      wr(7'h14, i == 0 ? 8'h01 : i == 1 ? 8'h10 : 8'h00);
      wr(7'h15, i == 2 ? 8'h01 : i == 3 ? 8'h10 : 8'h00);
      cyc(4);
      chk("position", 8'h01 << i, {4'h0, drv});
    end
    $display("Source select test done");
    // The switch is assigned to the second timer before any on-time is written.
    wr(7'h15, 8'h00);
    wr(7'h14, 8'h33);
    for (int c = 1; c < 6; c++) begin
      wr(7'h0d, {1'b0, c[2:0], 4'h6});
      measure(81);
      chk("on time", on_cyc[c] + 1, hi);
      if (c > 1) chk("sample", 8'h01, ns);
    end
    // One window longer than the period catches the whole first pulse and the first cycle of the second pulse.
    for (int p = 0; p < 7; p++) begin
      wr(7'h0d, {5'h02, p[2:0]});
      measure(per_cyc[p] + 1);
      chk("period", 8'h03, hi);
    end
    for (int i = 0; i < 4; i++) begin
      wr(7'h0d, spc[i]);
      measure(20);
      chk("still level", spx[i], hi);
    end
    $display("Timer test done");
    wr(7'h0d, 8'h00);
    wr(7'h14, 8'h11);
    @(posedge ref_clk) ov <= 1'b1;
    cyc(5);
    chk("ov drive", 8'h00, {4'h0, drv});
    chk("shutdown", 8'h01, {7'h0, shut});
    @(posedge ref_clk) ov <= 1'b0;
    cyc(5);
    chk("no recovery", 8'h00, {4'h0, drv});
    wr(7'h10, 8'h10);
    wr(7'h14, 8'h11);
    @(posedge ref_clk) uv <= 1'b1;
    cyc(5);
    chk("uv drive", 8'h00, {4'h0, drv});
    @(posedge ref_clk) uv <= 1'b0;
    cyc(5);
    chk("recovery", 8'h03, {4'h0, drv});
    wr(7'h10, 8'h70);
    @(posedge ref_clk) {ov, uv} <= 2'b11;
    cyc(5);
    chk("disabled", 8'h03, {4'h0, drv});
    @(posedge ref_clk) {ov, uv} <= 2'b00;
    $display("Supply shutdown test done");
    // Faults on switches three and two clear only their own fields.
    wr(7'h15, 8'h11);
    @(posedge ref_clk) {oc, ot} <= 8'h42;
    cyc(5);
    @(posedge ref_clk) {oc, ot} <= 8'h00;
    rdchk("fault b", 7'h15, 8'h10);
    rdchk("fault a", 7'h14, 8'h01);
    chk("fault drive", 8'h09, {4'h0, drv});
    $display("Fault clear test done");
    wr(7'h0d, 8'h16);
    wr(7'h14, 8'h33);
    @(posedge ref_clk) restart_mode <= 1'b1;
    cyc(3);
    rdchk("restart sd", 7'h10, 8'h70);
    rdchk("restart tmr", 7'h0d, 8'h00);
    rdchk("restart sel", 7'h14, 8'h00);
    wr(7'h14, 8'h03);
    wr(7'h0d, 8'h16);
    wr(7'h14, 8'h00);
    cyc(2);
    rdchk("restart clear", 7'h0d, 8'h00);
    @(posedge ref_clk) restart_mode <= 1'b0;
    $display("Restart test done");
    // A frozen clock enable must drop the write.
    @(posedge ref_clk) ce <= 1'b0;
    wr(7'h14, 8'h01);
    @(posedge ref_clk) ce <= 1'b1;
    rdchk("frozen", 7'h14, 8'h00);
    wr(7'h0d, 8'h16);
    @(posedge ref_clk) soft_rst <= 1'b1;
    @(posedge ref_clk) soft_rst <= 1'b0;
    for (int i = 0; i < 4; i++) rdchk("soft reset", adr[i], 8'h00);
    $display("Soft reset test done");
    tally_and_finish();
  end
endmodule : tb_top
